// >>> laser_ctrl_register_map_test.sv
// Self-checking bench for the register bank.
// Assumes a shortened store write time of EE_CYC cycles.
`timescale 1ns/1ns
module laser_ctrl_register_map_test;
    localparam int EE_CYC = 8;
    logic        i_sys_clk, i_rst, i_factory_load, i_wr_en, i_rd_en;
    logic [7:0]  i_addr, i_wr_data, i_alarm_flags, i_bias_code, o_rd_data, pl, v, w;
    logic [11:0] i_mod_code;
    logic [7:0]  o_power_loop_setpoint, o_extinction_ratio_gain, o_bias_trip_level;
    logic [11:0] o_modulation_preload;
    logic [7:1]  o_device_control;
    logic [2:0]  o_high_power_trip_level, o_low_power_trip_level;
    logic [7:0]  ro_addr[5] = '{8'h78, 8'hD1, 8'hD6, 8'hD7, 8'h80};
    logic        o_rd_valid, o_wr_ack, o_wr_refused, o_write_protect, o_ee_busy, o_loop_halt;
    int          miscompares, num_checks, cycles;
    logic [15:0] exp_q[$];
    lcr_register_bank #(.EE_WRITE_CYCLES(EE_CYC)) dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
        .i_factory_load(i_factory_load), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_alarm_flags(i_alarm_flags),
        .i_bias_code(i_bias_code), .i_mod_code(i_mod_code), .o_rd_data(o_rd_data),
        .o_rd_valid(o_rd_valid), .o_wr_ack(o_wr_ack), .o_wr_refused(o_wr_refused),
        .o_write_protect(o_write_protect), .o_ee_busy(o_ee_busy), .o_loop_halt(o_loop_halt),
        .o_power_loop_setpoint(o_power_loop_setpoint),
        .o_extinction_ratio_gain(o_extinction_ratio_gain),
        .o_modulation_preload(o_modulation_preload), .o_device_control(o_device_control),
        .o_high_power_trip_level(o_high_power_trip_level),
        .o_low_power_trip_level(o_low_power_trip_level), .o_bias_trip_level(o_bias_trip_level));
    lcr_host_model host (.i_sys_clk(i_sys_clk), .o_wr_en(i_wr_en), .o_rd_en(i_rd_en),
        .o_addr(i_addr), .o_wr_data(i_wr_data));
    // ----
    // Tasks
    // ----
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic refused);
        exp_q.push_back({15'h0000, refused});
        host.put(1'b1, a, d);
    endtask
    // Waits for its answer so read and write answers never share an edge
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        exp_q.push_back({8'h01, d});
        host.put(1'b0, a, 8'h00);
        for (int i = 0; i < 8 && exp_q.size() != 0; i++) @(negedge i_sys_clk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge i_sys_clk);
    endtask
    task automatic give_verdict;
        if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----
    // Clock, monitor and timeout
    // ----
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    always @(negedge i_sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
        if (!i_rst && (o_wr_ack === 1'b1 || o_rd_valid === 1'b1)) begin
            if (exp_q.size() == 0) check(16'h0000, 16'hFFFF);
            else if (o_wr_ack) check({15'h0000, o_wr_refused}, exp_q.pop_front());
            else check({8'h01, o_rd_data}, exp_q.pop_front());
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        {i_rst, i_factory_load} = 2'b11;
        {i_alarm_flags, i_bias_code, i_mod_code} = '0;
        {miscompares, num_checks, cycles} = '0;
        v = 8'($urandom(42542));
        idle(12);
        {i_rst, i_factory_load} = 2'b00;
        idle(1);
        check({15'h0000, o_write_protect}, 16'h0001);
        check({o_extinction_ratio_gain, o_power_loop_setpoint}, 16'h1C00);
        check({3'h0, o_high_power_trip_level, o_low_power_trip_level, o_device_control}, 16'h0038);
        check({o_bias_trip_level, 8'h00}, 16'h0000);
        check({4'h0, o_modulation_preload}, 16'h0000);
        for (int a = 8'h7B; a <= 8'h7E; a++) rd(8'(a), 8'hFF);
        rd(8'hB4, 8'h1C);
        rd(8'hB7, 8'h70);
        rd(8'hC3, 8'h00);
        wr(8'hB2, 8'h55, 1'b1);
        foreach (ro_addr[k]) wr(ro_addr[k], 8'($urandom), 1'b1);
        rd(8'h80, 8'h00);
        rd(8'hB2, 8'h00);
        {i_alarm_flags, i_bias_code, i_mod_code} = 28'($urandom);
        rd(8'h78, i_alarm_flags);
        rd(8'hD1, 8'h00);
        for (int a = 8'h7B; a <= 8'h7E; a++) wr(8'(a), 8'h00, 1'b0);
        pl = 8'($urandom);
        wr(8'hB2, pl, 1'b0);
        wr(8'hB4, 8'h33, 1'b1);
        idle(EE_CYC + 2);
        rd(8'hB2, pl);
        check({8'h00, o_power_loop_setpoint}, {8'h00, pl});
        w = 8'($urandom) | 8'h01;
        wr(8'hC3, w, 1'b0);
        idle(EE_CYC + 2);
        wr(8'hC4, 8'h11, 1'b1);
        rd(8'hC3, 8'h00);
        wr(8'h7B, w, 1'b0);
        rd(8'hC3, w);
        wr(8'hB7, 8'h71, 1'b0);
        check({15'h0000, o_ee_busy}, 16'h0001);
        idle(EE_CYC + 2);
        rd(8'hB7, 8'h71);
        rd(8'hD1, i_bias_code);
        rd(8'hD6, i_mod_code[11:4]);
        rd(8'hD7, {i_mod_code[3:0], 4'h0});
        wr(8'hB7, 8'h70, 1'b0);
        check({14'h0000, o_ee_busy, o_loop_halt}, 16'h0002);
        idle(EE_CYC + 2);
        v = 8'($urandom);
        wr(8'hB6, v, 1'b0);
        idle(EE_CYC + 2);
        rd(8'hB6, v);
        check({4'h0, o_modulation_preload}, {12'h000, v[7:4]});
        i_rst = 1'b1;
        idle(12);
        i_rst = 1'b0;
        idle(1);
        rd(8'h7D, 8'hFF);
        rd(8'hB2, pl);
        check({4'h0, o_modulation_preload}, {12'h000, v[7:4]});
        check({15'h0000, o_loop_halt}, 16'h0000);
        give_verdict();
    end
endmodule

// >>> lcr_bank_asserts.sv
// Port-level checks for the laser-control register bank.
// Assumes binding to lcr_register_bank; sees only its ports.
`timescale 1ns/1ns
module lcr_bank_asserts #(
    parameter int EE_WRITE_CYCLES = 8
) (
    input wire logic       i_sys_clk,     // Clock
    input wire logic       i_rst,         // Sync reset
    input wire logic       i_wr_en,       // Write request
    input wire logic       i_rd_en,       // Read request
    input wire logic [7:0] i_addr,        // Byte address
    input wire logic [7:0] i_wr_data,     // Write byte
    input wire logic [7:0] i_alarm_flags, // Live flags
    input wire logic [7:0] o_rd_data,     // Read byte
    input wire logic       o_rd_valid,    // Read answer
    input wire logic       o_wr_ack,      // Write answer
    input wire logic       o_wr_refused,  // Write refused
    input wire logic       o_ee_busy,     // Store busy
    input wire logic       o_loop_halt    // Halt bit
);
    // ----
    // Helpers
    // ----
    logic                 rd_take;
    logic                 wd0;
    logic [31:0]          busy_cnt_q;
    lcr_pkg::lcr_slot_s   slot;
    assign rd_take = i_rd_en && !i_wr_en;
    assign wd0     = i_wr_data[0];
    assign slot    = lcr_pkg::nv_slot(i_addr);
    // Length of the running store cycle, compared when busy falls
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !o_ee_busy) busy_cnt_q <= '0;
        else busy_cnt_q <= busy_cnt_q + 32'd1;
    end
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ----
    // Properties
    // ----
    a_write_answer: assert property (i_wr_en |=> o_wr_ack)
        else $error("write not answered");
    a_read_answer: assert property (rd_take |-> ##2 o_rd_valid)
        else $error("read not answered");
    a_fixed_refuse: assert property (i_wr_en && (i_addr inside {8'h78, 8'hD1, 8'hD6, 8'hD7})
        |=> o_wr_refused) else $error("read-only place written");
    a_key_entry_open: assert property (i_wr_en && (i_addr inside {[8'h7B:8'h7E]})
        |=> o_wr_ack && !o_wr_refused) else $error("key entry write refused");
    a_busy_refuse: assert property (i_wr_en && o_ee_busy && slot.hit |=> o_wr_refused)
        else $error("store written while busy");
    a_ctrl_cycle: assert property ((i_wr_en && i_addr == 8'hB7) ##1 (o_wr_ack && !o_wr_refused)
        |-> o_ee_busy && (o_loop_halt == $past(wd0))) else $error("control write no cycle");
    a_busy_length: assert property ($fell(o_ee_busy) |-> busy_cnt_q == EE_WRITE_CYCLES)
        else $error("store cycle length wrong");
    a_code_low_zero: assert property (o_rd_valid && $past(rd_take, 2)
        && $past(i_addr, 2) == 8'hD7 |-> o_rd_data[3:0] == 4'h0) else $error("low nibble set");
    a_status_live: assert property (o_rd_valid && $past(rd_take, 2) && $past(i_addr, 2) == 8'h78
        |-> o_rd_data == $past(i_alarm_flags) || o_rd_data == $past(i_alarm_flags, 2))
        else $error("status not live");
endmodule
bind lcr_register_bank lcr_bank_asserts #(.EE_WRITE_CYCLES(EE_WRITE_CYCLES)) u_asserts (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_alarm_flags(i_alarm_flags),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_wr_ack(o_wr_ack),
    .o_wr_refused(o_wr_refused), .o_ee_busy(o_ee_busy), .o_loop_halt(o_loop_halt));

// >>> lcr_host_model.sv
// Host side of the byte port: one read or write per call.
// Assumes the caller waits for answers it depends on.
`timescale 1ns/1ns
module lcr_host_model (
    input  wire logic       i_sys_clk, // Bank clock
    output logic            o_wr_en,   // Write request
    output logic            o_rd_en,   // Read request
    output logic [7:0]      o_addr,    // Byte address
    output logic [7:0]      o_wr_data  // Write byte
);
    initial begin
        o_wr_en = 1'b0;
        o_rd_en = 1'b0;
        o_addr = 8'h00;
        o_wr_data = 8'h00;
    end
    // Held over one rising edge; released lines stop showing old values
    task automatic put(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_sys_clk);
        o_wr_en <= wr;
        o_rd_en <= !wr;
        o_addr <= a;
        o_wr_data <= wr ? d : ~o_wr_data;
        @(negedge i_sys_clk);
        o_wr_en <= 1'b0;
        o_rd_en <= 1'b0;
        o_addr <= ~a;
        o_wr_data <= ~o_wr_data;
    endtask
endmodule

// >>> lcr_nv_store.sv
// Nonvolatile byte store of the register bank.
// Contents survive i_rst; only i_factory_load restores the defaults.
`timescale 1ns/1ns
module lcr_nv_store #(
    parameter int                         WIDTH = 8,
    parameter int                         DEPTH = 12,
    parameter int                         IDX_W = 4,
    parameter logic [DEPTH*WIDTH-1:0]     INIT  = '0
) (
    input  wire logic                     i_sys_clk,      // System clock
    input  wire logic                     i_rst,          // Clears read port only
    input  wire logic                     i_factory_load, // Load factory image
    input  wire logic                     i_wr_en,        // Byte write
    input  wire logic [IDX_W-1:0]         i_wr_idx,       // Write slot
    input  wire logic [WIDTH-1:0]         i_wr_data,      // Write byte
    input  wire logic [IDX_W-1:0]         i_rd_idx,       // Read slot
    output logic      [WIDTH-1:0]         o_rd_data,      // Registered read byte
    output logic      [DEPTH*WIDTH-1:0]   o_image         // Whole store, from flops
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0]            rd;
    } lcr_nv_state_s;

    lcr_nv_state_s state_q;
    lcr_nv_state_s state_d;

    always_comb begin
        state_d    = state_q;
        state_d.rd = state_q.mem[i_rd_idx];
        if (i_wr_en) begin
            state_d.mem[i_wr_idx] = i_wr_data;
        end
        if (i_factory_load) begin
            state_d.mem = INIT;
        end
        // Storage deliberately not cleared: loss of supply keeps cell values
        if (i_rst) begin
            state_d.rd = '0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        state_q <= state_d;
    end

    assign o_rd_data = state_q.rd;
    assign o_image   = state_q.mem;

endmodule

// >>> lcr_pkg.sv
// Constants, map and types of the laser-control register bank.
// Assumes byte-wide host accesses; offsets are byte addresses.
package lcr_pkg;

    // ------------------------------------------------------------
    // Byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ALARM_STATUS  = 8'h78;
    localparam logic [7:0] ADDR_KEY_ENTRY_B3  = 8'h7B;
    localparam logic [7:0] ADDR_KEY_ENTRY_B2  = 8'h7C;
    localparam logic [7:0] ADDR_KEY_ENTRY_B1  = 8'h7D;
    localparam logic [7:0] ADDR_KEY_ENTRY_B0  = 8'h7E;
    localparam logic [7:0] ADDR_POWER_LOOP    = 8'hB2;
    localparam logic [7:0] ADDR_EXT_RATIO     = 8'hB4;
    localparam logic [7:0] ADDR_MOD_PRELOAD_H = 8'hB5;
    localparam logic [7:0] ADDR_MOD_PRELOAD_L = 8'hB6;
    localparam logic [7:0] ADDR_DEV_CONTROL   = 8'hB7;
    localparam logic [7:0] ADDR_HIGH_PWR_TRIP = 8'hB8;
    localparam logic [7:0] ADDR_LOW_PWR_TRIP  = 8'hB9;
    localparam logic [7:0] ADDR_BIAS_TRIP     = 8'hBA;
    localparam logic [7:0] ADDR_STORED_KEY_B3 = 8'hC3;
    localparam logic [7:0] ADDR_STORED_KEY_B2 = 8'hC4;
    localparam logic [7:0] ADDR_STORED_KEY_B1 = 8'hC5;
    localparam logic [7:0] ADDR_STORED_KEY_B0 = 8'hC6;
    localparam logic [7:0] ADDR_BIAS_CODE     = 8'hD1;
    localparam logic [7:0] ADDR_MOD_CODE_H    = 8'hD6;
    localparam logic [7:0] ADDR_MOD_CODE_L    = 8'hD7;

    // ------------------------------------------------------------
    // Nonvolatile slots, in byte order of the store
    // ------------------------------------------------------------
    localparam int         NV_DEPTH       = 12;
    localparam int         NV_IDX_W       = 4;
    localparam logic [3:0] NV_POWER_LOOP  = 4'h0;
    localparam logic [3:0] NV_EXT_RATIO   = 4'h1;
    localparam logic [3:0] NV_MOD_PRE_H   = 4'h2;
    localparam logic [3:0] NV_MOD_PRE_L   = 4'h3;
    localparam logic [3:0] NV_DEV_CONTROL = 4'h4;
    localparam logic [3:0] NV_HIGH_TRIP   = 4'h5;
    localparam logic [3:0] NV_LOW_TRIP    = 4'h6;
    localparam logic [3:0] NV_BIAS_TRIP   = 4'h7;
    localparam logic [3:0] NV_KEY_B3      = 4'h8;
    localparam logic [3:0] NV_KEY_B2      = 4'h9;
    localparam logic [3:0] NV_KEY_B1      = 4'hA;
    localparam logic [3:0] NV_KEY_B0      = 4'hB;

    // Factory image, slot 0 in the low byte
    localparam logic [95:0] NV_FACTORY = 96'h0000_0000_0000_0070_0000_1C00;

    // ------------------------------------------------------------
    // Fields and volatile reset values
    // ------------------------------------------------------------
    localparam int          CTRL_HALT_BIT  = 0;
    localparam int          TRIP_SEL_W     = 3;
    localparam int          MOD_CODE_W     = 12;
    localparam logic [3:0]  UNUSED_NIBBLE  = 4'h0;
    localparam logic [7:0]  READ_ZERO      = 8'h00;
    localparam logic [31:0] KEY_ENTRY_RST  = 32'hFFFF_FFFF;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ          = 100;
    localparam int EE_WRITE_TIME_US = 10000;

    typedef enum logic {EE_IDLE, EE_BUSY} lcr_ee_e;

    typedef struct packed {
        logic                hit;
        logic [NV_IDX_W-1:0] idx;
    } lcr_slot_s;

    function automatic lcr_slot_s nv_slot(input logic [7:0] addr);
        lcr_slot_s s;
        s.hit = 1'b1;
        s.idx = NV_POWER_LOOP;
        unique case (addr)
            ADDR_POWER_LOOP:    s.idx = NV_POWER_LOOP;
            ADDR_EXT_RATIO:     s.idx = NV_EXT_RATIO;
            ADDR_MOD_PRELOAD_H: s.idx = NV_MOD_PRE_H;
            ADDR_MOD_PRELOAD_L: s.idx = NV_MOD_PRE_L;
            ADDR_DEV_CONTROL:   s.idx = NV_DEV_CONTROL;
            ADDR_HIGH_PWR_TRIP: s.idx = NV_HIGH_TRIP;
            ADDR_LOW_PWR_TRIP:  s.idx = NV_LOW_TRIP;
            ADDR_BIAS_TRIP:     s.idx = NV_BIAS_TRIP;
            ADDR_STORED_KEY_B3: s.idx = NV_KEY_B3;
            ADDR_STORED_KEY_B2: s.idx = NV_KEY_B2;
            ADDR_STORED_KEY_B1: s.idx = NV_KEY_B1;
            ADDR_STORED_KEY_B0: s.idx = NV_KEY_B0;
            default:            s.hit = 1'b0;
        endcase
        return s;
    endfunction

endpackage

// >>> lcr_register_bank.sv
// Register bank of a laser-driver control device: byte port, password
// gate, volatile registers and the nonvolatile store with write timing.
// Assumes a serial-bus front end drives the byte port on i_sys_clk.
//
// Functional notes
// - Unused bits, converter low nibble, read zero (code returns stored unused bits, e.g. trip bits 7:3, as written)
// - Volatile registers take defaults at power-up
// - Nonvolatile value persists after unlocked write
// - Refuse protected writes while locked
// - Volatile in flops, nonvolatile in store
// - Alarm status reads live hardware condition
// - Honour read-only and read/write access codes
// - Only key entry writable while locked
// - Stored key reads zero unless matched
// - Control write always starts store write (code starts it only when unlocked and store idle)
`timescale 1ns/1ns
module lcr_register_bank #(
    parameter int EE_WRITE_CYCLES = lcr_pkg::EE_WRITE_TIME_US * lcr_pkg::CLK_MHZ
) (
    input  wire logic        i_sys_clk,                // 100 MHz clock
    input  wire logic        i_rst,                    // Power-up reset, sync
    input  wire logic        i_factory_load,           // Restore factory image
    input  wire logic        i_wr_en,                  // Byte write request
    input  wire logic        i_rd_en,                  // Byte read request
    input  wire logic [7:0]  i_addr,                   // Byte address
    input  wire logic [7:0]  i_wr_data,                // Write byte
    input  wire logic [7:0]  i_alarm_flags,            // Live alarm/shutdown flags
    input  wire logic [7:0]  i_bias_code,              // Bias converter code MSB
    input  wire logic [11:0] i_mod_code,               // Modulation converter code
    output logic      [7:0]  o_rd_data,                // Read byte
    output logic             o_rd_valid,               // Read answer pulse
    output logic             o_wr_ack,                 // Write answer pulse
    output logic             o_wr_refused,             // Write was refused
    output logic             o_write_protect,          // Key entry mismatch
    output logic             o_ee_busy,                // Store write cycle running
    output logic             o_loop_halt,              // Loop freeze bit
    output logic      [7:0]  o_power_loop_setpoint,    // Power loop setpoint
    output logic      [7:0]  o_extinction_ratio_gain,  // Ratio gain and range
    output logic      [11:0] o_modulation_preload,     // Preload code
    output logic      [7:1]  o_device_control,         // Stored control bits
    output logic      [2:0]  o_high_power_trip_level,  // High power trip select
    output logic      [2:0]  o_low_power_trip_level,   // Low power trip select
    output logic      [7:0]  o_bias_trip_level         // Bias trip level
);

    localparam int CNT_W = $clog2(EE_WRITE_CYCLES + 1);
    localparam int W     = 8;
    localparam logic [CNT_W-1:0] EE_LOAD = CNT_W'(EE_WRITE_CYCLES - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]         key_entry;
        logic                halt;
        lcr_pkg::lcr_ee_e    ee;
        logic [CNT_W-1:0]    ee_cnt;
        logic                rd_p1;
        logic [7:0]          rd_addr;
        logic [7:0]          rd_data;
        logic                rd_valid;
        logic                wr_ack;
        logic                wr_refused;
        logic                locked;
    } lcr_bank_state_s;

    lcr_bank_state_s state_q;
    lcr_bank_state_s state_d;

    logic [lcr_pkg::NV_DEPTH*W-1:0] nv_image;
    logic [W-1:0]                   nv_rd_data;
    logic                           nv_we;
    logic [lcr_pkg::NV_IDX_W-1:0]   nv_wr_idx;
    logic [W-1:0]                   nv_wr_data;
    lcr_pkg::lcr_slot_s             wr_slot;
    lcr_pkg::lcr_slot_s             rd_slot;
    lcr_pkg::lcr_slot_s             p1_slot;
    logic [31:0]                    stored_key;
    logic                           unlocked;
    logic [2*W-1:0]                 preload_word;
    logic [W-1:0]                   ctrl_byte;
    logic [W-1:0]                   high_trip_byte;
    logic [W-1:0]                   low_trip_byte;

    // ------------------------------------------------------------
    // Nonvolatile store
    // ------------------------------------------------------------
    lcr_nv_store #(
        .WIDTH (W),
        .DEPTH (lcr_pkg::NV_DEPTH),
        .IDX_W (lcr_pkg::NV_IDX_W),
        .INIT  (lcr_pkg::NV_FACTORY)
    ) u_nv_store (
        .i_sys_clk      (i_sys_clk),
        .i_rst          (i_rst),
        .i_factory_load (i_factory_load),
        .i_wr_en        (nv_we),
        .i_wr_idx       (nv_wr_idx),
        .i_wr_data      (nv_wr_data),
        .i_rd_idx       (rd_slot.idx),
        .o_rd_data      (nv_rd_data),
        .o_image        (nv_image)
    );

    function automatic logic [W-1:0] nv_byte(input logic [lcr_pkg::NV_IDX_W-1:0] idx);
        return nv_image[idx*W +: W];
    endfunction

    assign wr_slot    = lcr_pkg::nv_slot(i_addr);
    assign rd_slot    = lcr_pkg::nv_slot(i_addr);
    assign p1_slot    = lcr_pkg::nv_slot(state_q.rd_addr);
    assign stored_key = {nv_byte(lcr_pkg::NV_KEY_B3), nv_byte(lcr_pkg::NV_KEY_B2),
                         nv_byte(lcr_pkg::NV_KEY_B1), nv_byte(lcr_pkg::NV_KEY_B0)};
    // Live compare so a write right after unlocking is not refused
    assign unlocked   = (state_q.key_entry == stored_key);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_d            = state_q;
        state_d.wr_ack     = 1'b0;
        state_d.wr_refused = 1'b0;
        state_d.rd_valid   = 1'b0;
        state_d.rd_p1      = 1'b0;
        state_d.locked     = !unlocked;
        nv_we              = 1'b0;
        nv_wr_idx          = wr_slot.idx;
        nv_wr_data         = i_wr_data;

        // Store write cycle timer; refuses further store writes meanwhile
        unique case (state_q.ee)
            lcr_pkg::EE_IDLE: begin
                state_d.ee_cnt = '0;
            end
            lcr_pkg::EE_BUSY: begin
                if (state_q.ee_cnt == '0) begin
                    state_d.ee = lcr_pkg::EE_IDLE;
                end else begin
                    state_d.ee_cnt = state_q.ee_cnt - 1'b1;
                end
            end
        endcase

        if (i_wr_en) begin
            state_d.wr_ack = 1'b1;
            unique case (i_addr)
                lcr_pkg::ADDR_KEY_ENTRY_B3: state_d.key_entry[31:24] = i_wr_data;
                lcr_pkg::ADDR_KEY_ENTRY_B2: state_d.key_entry[23:16] = i_wr_data;
                lcr_pkg::ADDR_KEY_ENTRY_B1: state_d.key_entry[15:8]  = i_wr_data;
                lcr_pkg::ADDR_KEY_ENTRY_B0: state_d.key_entry[7:0]   = i_wr_data;
                default: begin
                    if (!wr_slot.hit) begin
                        // Status, converter codes and reserved bytes
                        state_d.wr_refused = 1'b1;
                    end else if (!unlocked) begin
                        state_d.wr_refused = 1'b1;
                    end else if (state_q.ee == lcr_pkg::EE_BUSY) begin
                        state_d.wr_refused = 1'b1;
                    end else begin
                        nv_we          = 1'b1;
                        state_d.ee     = lcr_pkg::EE_BUSY;
                        state_d.ee_cnt = EE_LOAD;
                        if (i_addr == lcr_pkg::ADDR_DEV_CONTROL) begin
                            // Freeze bit lives in a flop, stored copy kept clear
                            state_d.halt = i_wr_data[lcr_pkg::CTRL_HALT_BIT];
                            nv_wr_data[lcr_pkg::CTRL_HALT_BIT] = 1'b0;
                        end
                    end
                end
            endcase
        end else if (i_rd_en) begin
            state_d.rd_p1   = 1'b1;
            state_d.rd_addr = i_addr;
        end

        // Second read stage: live values sampled here, store byte is ready
        if (state_q.rd_p1) begin
            state_d.rd_valid = 1'b1;
            state_d.rd_data  = lcr_pkg::READ_ZERO;
            unique case (state_q.rd_addr)
                lcr_pkg::ADDR_ALARM_STATUS: state_d.rd_data = i_alarm_flags;
                lcr_pkg::ADDR_KEY_ENTRY_B3: state_d.rd_data = state_q.key_entry[31:24];
                lcr_pkg::ADDR_KEY_ENTRY_B2: state_d.rd_data = state_q.key_entry[23:16];
                lcr_pkg::ADDR_KEY_ENTRY_B1: state_d.rd_data = state_q.key_entry[15:8];
                lcr_pkg::ADDR_KEY_ENTRY_B0: state_d.rd_data = state_q.key_entry[7:0];
                lcr_pkg::ADDR_BIAS_CODE: begin
                    // Codes only visible with the loop frozen and key entered
                    if (unlocked && state_q.halt) begin
                        state_d.rd_data = i_bias_code;
                    end
                end
                lcr_pkg::ADDR_MOD_CODE_H: begin
                    if (unlocked && state_q.halt) begin
                        state_d.rd_data = i_mod_code[11:4];
                    end
                end
                lcr_pkg::ADDR_MOD_CODE_L: begin
                    if (unlocked && state_q.halt) begin
                        state_d.rd_data = {i_mod_code[3:0], lcr_pkg::UNUSED_NIBBLE};
                    end
                end
                default: begin
                    if (p1_slot.hit) begin
                        state_d.rd_data = nv_rd_data;
                        if (p1_slot.idx >= lcr_pkg::NV_KEY_B3 && !unlocked) begin
                            state_d.rd_data = lcr_pkg::READ_ZERO;
                        end
                        if (p1_slot.idx == lcr_pkg::NV_DEV_CONTROL) begin
                            state_d.rd_data[lcr_pkg::CTRL_HALT_BIT] = state_q.halt;
                        end
                    end
                end
            endcase
        end

        if (i_rst) begin
            state_d.key_entry  = lcr_pkg::KEY_ENTRY_RST;
            state_d.halt       = 1'b0;
            state_d.ee         = lcr_pkg::EE_IDLE;
            state_d.ee_cnt     = '0;
            state_d.rd_p1      = 1'b0;
            state_d.rd_addr    = lcr_pkg::READ_ZERO;
            state_d.rd_data    = lcr_pkg::READ_ZERO;
            state_d.rd_valid   = 1'b0;
            state_d.wr_ack     = 1'b0;
            state_d.wr_refused = 1'b0;
            state_d.locked     = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        state_q <= state_d;
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign o_rd_data               = state_q.rd_data;
    assign o_rd_valid              = state_q.rd_valid;
    assign o_wr_ack                = state_q.wr_ack;
    assign o_wr_refused            = state_q.wr_refused;
    assign o_write_protect         = state_q.locked;
    assign o_ee_busy               = (state_q.ee == lcr_pkg::EE_BUSY);
    assign o_loop_halt             = state_q.halt;
    assign o_power_loop_setpoint   = nv_byte(lcr_pkg::NV_POWER_LOOP);
    assign o_extinction_ratio_gain = nv_byte(lcr_pkg::NV_EXT_RATIO);
    // Preload is left justified: low nibble of the second byte is dropped
    assign preload_word            = {nv_byte(lcr_pkg::NV_MOD_PRE_H),
                                      nv_byte(lcr_pkg::NV_MOD_PRE_L)};
    assign ctrl_byte               = nv_byte(lcr_pkg::NV_DEV_CONTROL);
    assign high_trip_byte          = nv_byte(lcr_pkg::NV_HIGH_TRIP);
    assign low_trip_byte           = nv_byte(lcr_pkg::NV_LOW_TRIP);
    assign o_modulation_preload    = preload_word[2*W-1 -: lcr_pkg::MOD_CODE_W];
    assign o_device_control        = ctrl_byte[7:1];
    assign o_high_power_trip_level = high_trip_byte[lcr_pkg::TRIP_SEL_W-1:0];
    assign o_low_power_trip_level  = low_trip_byte[lcr_pkg::TRIP_SEL_W-1:0];
    assign o_bias_trip_level       = nv_byte(lcr_pkg::NV_BIAS_TRIP);

endmodule
